//--- hdl/plpg_guard.sv
`timescale 1ns/1ps
`include "plpg_consts.svh"

// Operation
// - Writing nonzero to password_function enables the lock and stores that password.
// - While locked, all settings including the password are refused until unlock.
// - Confirm of a changed setting while locked does not write it and shows Err.
// - Opening shows encoded password; first arrow shows 0000, then entered digits.
// - Confirm with matching entry shows PASS and unlocks editing.
// - Unlock window is 5 minutes, restarted by every key press.
// - After 5 idle minutes the lock returns with the stored password.
// - Writing 0 while unlocked disables the lock until nonzero is written.
// - Writing a new nonzero value while unlocked replaces the password.
// - Stored password only shown encoded; zero password reads 3552.
// - Entries limited to 0000..0999, digit by digit with arrow keys.
// - After storing, End flashes, then the function number returns.
// - Confirm with wrong entry flashes Err and stays locked.
// - Factory default restore leaves password and lock state alone.
// - Out of reset the password is zero and the lock disabled.
module plpg_guard #(
   parameter int TICK_CYC = `PLPG_CLK_HZ / 1000 * `PLPG_TICK_MS,
   parameter int RELOCK_MS = `PLPG_RELOCK_MIN * 60000,
   parameter int FLASH_MS = `PLPG_FLASH_MS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Keypad and menu
   input plpg_pkg::plpg_keys_t keys,
   input wire logic in_pw_func,
   input wire logic store_req,
   input wire logic defaults_req,
   // Parameter store
   output logic store_we,
   output logic defaults_we,
   // Status and display
   output logic lock_en,
   output logic locked,
   output plpg_pkg::plpg_disp_t disp
);
   import plpg_pkg::*;

   localparam int TW = $clog2(TICK_CYC + 1);
   localparam int MW = $clog2(RELOCK_MS + FLASH_MS + 1);

   logic [15:0] pw, next_pw;
   logic [15:0] entry, next_entry;
   logic [15:0] enc;
   logic [1:0] cursor, next_cursor;
   logic entering, next_entering;
   logic open_d, next_open_d;
   logic [TW-1:0] tick_cnt, next_tick_cnt;
   logic [MW-1:0] idle_ms, next_idle_ms;
   logic [MW-1:0] flash_ms, next_flash_ms;
   logic next_lock_en, next_locked, next_store_we, next_defaults_we;
   plpg_dmode_t mode, next_mode;
   logic [15:0] next_digits;
   plpg_disp_t next_disp;
   logic any_key, arrow, tick_last, flashing, relock_due;

   // Digit-wise encoding of the stored password
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_enc
         logic [4:0] sum;
         assign sum = {1'b0, pw[gi*4 +: 4]} + {1'b0, 4'(`PLPG_ENC_KEY >> (gi*4))};
         assign enc[gi*4 +: 4] = (sum >= 5'h0a) ? 4'(sum - 5'h0a) : sum[3:0];
      end
   endgenerate

   function automatic logic [3:0] bump(input logic [3:0] d, input logic up);
      if (up) begin
         bump = (d == 4'h9) ? 4'h0 : d + 4'h1;
      end else begin
         bump = (d == 4'h0) ? 4'h9 : d - 4'h1;
      end
   endfunction

   assign any_key = |keys;
   assign arrow = keys.up | keys.down | keys.left | keys.right;
   assign tick_last = (tick_cnt == TW'(TICK_CYC - 1));
   assign flashing = (mode == DM_PASS) || (mode == DM_ERR) || (mode == DM_END);
   assign relock_due = locked == 1'b0 && lock_en && tick_last && !any_key
      && idle_ms == MW'(RELOCK_MS - 1);

   always_comb begin
      next_pw = pw;
      next_entry = entry;
      next_cursor = cursor;
      next_entering = entering;
      next_open_d = open_d;
      next_tick_cnt = tick_cnt;
      next_idle_ms = idle_ms;
      next_flash_ms = flash_ms;
      next_lock_en = lock_en;
      next_locked = locked;
      next_mode = mode;
      // Pulses hold with everything else while frozen
      next_store_we = store_we;
      next_defaults_we = defaults_we;
      if (ce) begin
         next_store_we = 1'b0;
         next_defaults_we = 1'b0;
         next_open_d = in_pw_func;
         next_tick_cnt = tick_last ? '0 : tick_cnt + TW'(1);
         // Inactivity window
         if (any_key || !lock_en || locked) begin
            next_idle_ms = '0;
         end else if (tick_last) begin
            next_idle_ms = idle_ms + MW'(1);
         end
         if (relock_due) begin
            next_locked = 1'b1;
            next_idle_ms = '0;
         end
         // Flash timing
         if (flashing && tick_last) begin
            if (flash_ms == MW'(FLASH_MS - 1)) begin
               next_mode = DM_FUNC;
               next_flash_ms = '0;
            end else begin
               next_flash_ms = flash_ms + MW'(1);
            end
         end
         if (!in_pw_func && !flashing) begin
            next_mode = DM_FUNC;
            next_entering = 1'b0;
         end
         if (in_pw_func && !open_d) begin
            next_mode = DM_CODE;
            next_entering = 1'b0;
         end
         // Digit entry
         if (in_pw_func && open_d && !flashing && arrow) begin
            if (!entering) begin
               next_entering = 1'b1;
               next_entry = '0;
               next_cursor = '0;
               next_mode = DM_ENTRY;
            end else if (keys.left) begin
               if (cursor != `PLPG_CUR_MAX) next_cursor = cursor + 2'h1;
            end else if (keys.right) begin
               if (cursor != 2'h0) next_cursor = cursor - 2'h1;
            end else begin
               next_entry[cursor*4 +: 4] = bump(entry[cursor*4 +: 4], keys.up);
            end
         end
         // Confirm at the password function
         if (in_pw_func && open_d && !flashing && keys.enter && entering) begin
            next_entering = 1'b0;
            next_flash_ms = '0;
            if (locked) begin
               if (entry == pw) begin
                  next_locked = 1'b0;
                  next_mode = DM_PASS;
               end else begin
                  next_mode = DM_ERR;
               end
            end else if (entry == `PLPG_PW_NONE) begin
               next_lock_en = 1'b0;
               next_mode = DM_END;
            end else begin
               next_pw = entry;
               next_lock_en = 1'b1;
               next_locked = !lock_en;
               next_mode = DM_END;
            end
         end
         // Stores to other functions
         if (store_req || defaults_req) begin
            if (locked) begin
               next_mode = DM_ERR;
               next_flash_ms = '0;
            end else begin
               next_store_we = store_req;
               next_defaults_we = defaults_req;
            end
         end
      end
      unique case (next_mode)
         DM_CODE: next_digits = enc;
         DM_ENTRY: next_digits = next_entry;
         DM_FUNC, DM_PASS, DM_ERR, DM_END: next_digits = '0;
         default: next_digits = '0;
      endcase
      next_disp = disp;
      if (ce) begin
         next_disp = '{mode: next_mode, digits: next_digits};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pw <= `PLPG_PW_NONE;
         lock_en <= 1'b0;
         locked <= 1'b0;
         entry <= '0;
         cursor <= '0;
         entering <= 1'b0;
         open_d <= 1'b0;
         tick_cnt <= '0;
         idle_ms <= '0;
         flash_ms <= '0;
         mode <= DM_FUNC;
         store_we <= 1'b0;
         defaults_we <= 1'b0;
         disp <= '{mode: DM_FUNC, digits: 16'h0000};
      end else begin
         pw <= next_pw;
         lock_en <= next_lock_en;
         locked <= next_locked;
         entry <= next_entry;
         cursor <= next_cursor;
         entering <= next_entering;
         open_d <= next_open_d;
         tick_cnt <= next_tick_cnt;
         idle_ms <= next_idle_ms;
         flash_ms <= next_flash_ms;
         mode <= next_mode;
         store_we <= next_store_we;
         defaults_we <= next_defaults_we;
         disp <= next_disp;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   logic cfm;
   assign cfm = ce && in_pw_func && open_d && !flashing && keys.enter && entering;

   property p_set_pw;
      cfm && !locked && entry != 16'h0000 |=> lock_en && pw == $past(entry);
   endproperty
   a_set_pw: assert property (p_set_pw) else $error("password not stored");

   property p_refuse;
      ce && (store_req || defaults_req) && locked |=> !store_we && !defaults_we && mode == DM_ERR;
   endproperty
   a_refuse: assert property (p_refuse) else $error("store passed while locked");

   property p_no_pw_change;
      locked && !relock_due |=> pw == $past(pw) && lock_en == $past(lock_en);
   endproperty
   a_no_pw_change: assert property (p_no_pw_change) else $error("password changed");

   property p_first_arrow;
      ce && in_pw_func && open_d && !flashing && arrow && !entering
         |=> disp.mode == DM_ENTRY && disp.digits == 16'h0000;
   endproperty
   a_first_arrow: assert property (p_first_arrow) else $error("no 0000 on first arrow");

   property p_accept;
      cfm && locked && entry == pw |=> !locked && disp.mode == DM_PASS;
   endproperty
   a_accept: assert property (p_accept) else $error("correct entry not accepted");

   property p_reject;
      cfm && locked && entry != pw |=> locked && disp.mode == DM_ERR;
   endproperty
   a_reject: assert property (p_reject) else $error("wrong entry accepted");

   property p_window;
      ce && any_key |=> idle_ms == 0;
   endproperty
   a_window: assert property (p_window) else $error("window not restarted");

   property p_relock;
      relock_due && ce |=> locked && lock_en && pw == $past(pw);
   endproperty
   a_relock: assert property (p_relock) else $error("no relock on timeout");

   property p_disable;
      cfm && !locked && entry == 16'h0000 |=> !lock_en ##1 (!lock_en || cfm);
   endproperty
   a_disable: assert property (p_disable) else $error("lock not disabled");

   property p_code;
      disp.mode == DM_CODE && pw == 16'h0000 |-> disp.digits == 16'h3552;
   endproperty
   a_code: assert property (p_code) else $error("zero password not 3552");

   property p_range;
      entry[15:12] == 4'h0 && entry[3:0] <= 4'h9;
   endproperty
   a_range: assert property (p_range) else $error("entry out of range");

   property p_end;
      cfm && !locked |=> disp.mode == DM_END;
   endproperty
   a_end: assert property (p_end) else $error("no End flash");

   property p_restore;
      ce && defaults_req && !locked && !cfm
         |=> defaults_we && pw == $past(pw) && lock_en == $past(lock_en);
   endproperty
   a_restore: assert property (p_restore) else $error("restore touched password");

   // Lock, store pulse and display must not move while the enable is low
   property p_freeze;
      !ce |=> $stable(locked) && $stable(lock_en) && $stable(store_we) && $stable(disp);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");

   c_unlock: cover property (cfm && locked && entry == pw);
   c_relock: cover property (relock_due && ce);
   c_disable: cover property (cfm && !locked && entry == 16'h0000);
   c_refused: cover property (ce && store_req && locked);

endmodule // plpg_guard

//--- inc/plpg_consts.svh
`ifndef PLPG_CONSTS_SVH
`define PLPG_CONSTS_SVH

// System clock rate in Hz
`define PLPG_CLK_HZ 25000000
// One slow tick per millisecond
`define PLPG_TICK_MS 1
// Inactivity relock time in minutes
`define PLPG_RELOCK_MIN 5
// Length of a PASS / Err / End flash in ms
`define PLPG_FLASH_MS 500
// Per-digit offsets of the password encoding
`define PLPG_ENC_KEY 16'h3552
// Value that disables the lock
`define PLPG_PW_NONE 16'h0000
// Highest digit position the cursor may reach (hundreds)
`define PLPG_CUR_MAX 2'h2

`endif

//--- inc/plpg_pkg.sv
package plpg_pkg;

   // Keypad presses, one-cycle pulses
   typedef struct packed {
      logic fn;
      logic up;
      logic down;
      logic left;
      logic right;
      logic enter;
   } plpg_keys_t;

   // What the display shows
   typedef enum logic [5:0] {
      DM_FUNC = 6'h01,
      DM_CODE = 6'h02,
      DM_ENTRY = 6'h04,
      DM_PASS = 6'h08,
      DM_ERR = 6'h10,
      DM_END = 6'h20
   } plpg_dmode_t;

   typedef struct packed {
      plpg_dmode_t mode;
      logic [15:0] digits;
   } plpg_disp_t;

endpackage

//--- tb/plpg_keypad.sv
`timescale 1ns/1ps
// Operator keypad, one-cycle pulse per press
module plpg_keypad (
   // Clock
   input wire logic clk,
   // Presses toward the guard
   output plpg_pkg::plpg_keys_t keys
);
   import plpg_pkg::*;
   initial keys = '0;
   // Release edge kept apart from the next press
   task automatic press(input plpg_keys_t k);
      @(posedge clk) keys <= k;
      @(posedge clk) keys <= '0;
   endtask
endmodule // plpg_keypad

//--- tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
   cmp_count++; \
   if ((g) !== (e)) begin \
      fail_count++; \
      $display("unexpected %s: expected %0h seen %0h", nm, e, g); \
   end \
end
module tb_top;
   import plpg_pkg::*;
   localparam plpg_keys_t K_FN = 6'h20;
   localparam plpg_keys_t K_UP = 6'h10;
   localparam plpg_keys_t K_LEFT = 6'h04;
   localparam plpg_keys_t K_ENT = 6'h01;
   localparam plpg_keys_t K_DOWN = 6'h08;
   localparam plpg_keys_t K_RIGHT = 6'h02;
   logic clk, rst_n, ce, in_pw_func, store_req, defaults_req;
   logic store_we, defaults_we, lock_en, locked;
   plpg_keys_t keys;
   plpg_disp_t disp;
   int fail_count = 0;
   int cmp_count = 0;
   plpg_keypad u_pad (.clk(clk), .keys(keys));
   plpg_guard #(.TICK_CYC(4), .RELOCK_MS(20), .FLASH_MS(3)) u_dut (
      .clk(clk), .rst_n(rst_n), .ce(ce), .keys(keys), .in_pw_func(in_pw_func),
      .store_req(store_req), .defaults_req(defaults_req), .store_we(store_we),
      .defaults_we(defaults_we), .lock_en(lock_en), .locked(locked), .disp(disp));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic give_verdict();
      $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic wait_func();
      #1;
      for (int i = 0; i < 40; i++) begin
         if (disp.mode === DM_FUNC) return;
         @(posedge clk) #1;
      end
      fail_count++;
      $display("unexpected flash end: expected %0h seen %0h", DM_FUNC, disp.mode);
      give_verdict();
   endtask
   // Store or restore request, allowed or refused
   task automatic req(input bit dflt, input bit allow);
      @(posedge clk);
      if (dflt) defaults_req <= 1'b1;
      else store_req <= 1'b1;
      @(posedge clk);
      defaults_req <= 1'b0;
      store_req <= 1'b0;
      #1;
      `CHK("write enable", allow, dflt ? defaults_we : store_we)
      `CHK("store mode", allow ? DM_FUNC : DM_ERR, disp.mode)
      wait_func();
   endtask
   // Open, read code, key in value, confirm, judge, close
   task automatic enter_pw(input logic [15:0] code, input int h, t, u,
         input plpg_dmode_t md, input logic len, input logic lkd);
      @(posedge clk) in_pw_func <= 1'b1;
      @(posedge clk) #1;
      `CHK("code mode", DM_CODE, disp.mode)
      `CHK("code digits", code, disp.digits)
      u_pad.press(K_UP);
      #1;
      `CHK("cleared entry", 16'h0000, disp.digits)
      u_pad.press(K_DOWN);
      #1;
      `CHK("wrapped digit", 16'h0009, disp.digits)
      u_pad.press(K_UP);
      repeat (u) u_pad.press(K_UP);
      u_pad.press(K_LEFT);
      repeat (t) u_pad.press(K_UP);
      // Third left must stop at hundreds
      repeat (2) u_pad.press(K_LEFT);
      repeat (h) u_pad.press(K_UP);
      // Back to tens, one down, then restore
      u_pad.press(K_RIGHT);
      u_pad.press(K_DOWN);
      #1;
      `CHK("tens down", 16'(h * 256 + ((t + 9) % 10) * 16 + u), disp.digits)
      u_pad.press(K_UP);
      #1;
      `CHK("entry digits", 16'(h * 256 + t * 16 + u), disp.digits)
      u_pad.press(K_ENT);
      #1;
      `CHK("result mode", md, disp.mode)
      `CHK("lock enable", len, lock_en)
      `CHK("locked", lkd, locked)
      @(posedge clk) in_pw_func <= 1'b0;
      wait_func();
   endtask
   task automatic t_reset();
      #1;
      `CHK("reset lock enable", 1'b0, lock_en)
      `CHK("reset locked", 1'b0, locked)
      `CHK("reset mode", DM_FUNC, disp.mode)
      req(1'b0, 1'b1);
      $display("test reset done");
   endtask
   task automatic t_set();
      enter_pw(16'h3552, 1, 2, 3, DM_END, 1'b1, 1'b1);
      req(1'b0, 1'b0);
      req(1'b1, 1'b0);
      `CHK("lock after restore", 1'b1, lock_en)
      enter_pw(16'h3675, 1, 2, 2, DM_ERR, 1'b1, 1'b1);
      $display("test set and refuse done");
   endtask
   task automatic t_unlock();
      enter_pw(16'h3675, 1, 2, 3, DM_PASS, 1'b1, 1'b0);
      req(1'b0, 1'b1);
      req(1'b1, 1'b1);
      `CHK("lock after restore", 1'b1, lock_en)
      $display("test unlock done");
   endtask
   task automatic t_window();
      u_pad.press(K_FN);
      repeat (60) @(posedge clk);
      u_pad.press(K_FN);
      repeat (60) @(posedge clk);
      #1;
      `CHK("window kept", 1'b0, locked)
      // Frozen long enough that a running timer would have relocked
      @(posedge clk) ce <= 1'b0;
      repeat (40) @(posedge clk);
      ce <= 1'b1;
      #1;
      `CHK("window frozen", 1'b0, locked)
      for (int i = 0; i < 40 && locked !== 1'b1; i++) @(posedge clk) #1;
      `CHK("relocked", 1'b1, locked)
      if (locked !== 1'b1) give_verdict();
      $display("test window done");
   endtask
   task automatic t_change();
      enter_pw(16'h3675, 1, 2, 3, DM_PASS, 1'b1, 1'b0);
      enter_pw(16'h3675, 0, 0, 5, DM_END, 1'b1, 1'b0);
      enter_pw(16'h3557, 0, 0, 0, DM_END, 1'b0, 1'b0);
      req(1'b0, 1'b1);
      $display("test change done");
   endtask
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      in_pw_func = 1'b0;
      store_req = 1'b0;
      defaults_req = 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_set();
      t_unlock();
      t_window();
      t_change();
      give_verdict();
   end
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      $display("unexpected run length: expected 0 seen 1");
      give_verdict();
   end
endmodule // tb_top
